// *** core/cpu_ctl_consts.vh ***
`ifndef CPU_CTL_CONSTS_VH
`define CPU_CTL_CONSTS_VH
// processor-control opcodes
`define OP_DIR_SET        8'hFD
`define OP_INT_CLR        8'hFA
`define OP_INT_SET        8'hFB
`define OP_HALT           8'hF4
`define OP_WAIT           8'h9B
`define OP_LOCK           8'hF0
`define ESC_TOP           5'h1B
// clock counts per instruction
`define CYC_SHORT         4'h2
`define CYC_WAIT          4'h3
`define CYC_ESC_BASE      4'h7
// flag bit positions
`define FLAG_CARRY        0
`define FLAG_ZERO         6
`define FLAG_SIGN         7
`define FLAG_TRAP         8
`define FLAG_INT          9
`define FLAG_DIR          10
`define FLAG_OVF          11
// reset values
`define RST_FLAGS         16'h0000
`define RST_CODE_SEG      16'hFFFF
`define RST_SEG           16'h0000
`define RST_IP            16'h0000
// vector slot spacing in bytes
`define VEC_BYTES         4
// register-port offsets
`define REG_FLAGS         4'h0
`define REG_CODE_SEG      4'h1
`define REG_IP            4'h2
`define REG_DATA_SEG      4'h3
`define REG_STACK_SEG     4'h4
`define REG_EXTRA_SEG     4'h5
`define REG_STATUS        4'h6
`define REG_COUNT         4'h7
`endif

// *** core/cpu_control_decode.v ***
// Contract
// - d bit set means register is destination
// - w bit set means word, clear byte
// - s:w 01 takes full 16-bit immediate
// - s:w 11 sign-extends one immediate byte
// - v clear count one, set low count byte
// - string repeat compares z bit with zero flag
// - above/below uses carry and zero flags
// - greater/less uses signed sign/overflow/zero flags
// - reset clears flags, data, stack, extra segments
// - reset loads code segment ones, pointer zero
// - reset leaves general registers untouched
// - types 0-4 vectors at type times four
// - direction set opcode sets flag, 2 clocks
// - interrupt clear opcode clears flag, 2 clocks
// - interrupt set opcode sets flag, 2 clocks
// - halt opcode, 2 clocks, no flags
// - wait opcode, 3 clocks base, no flags
// - lock prefix, 2 clocks, next instruction
// - escape 11011xxx, 7 plus address time
// shared opcode, offset and timing constants
`include "cpu_ctl_consts.vh"
module cpu_control_decode (
    // clock and reset
    input  wire        CLK_SYS,
    input  wire        RST,
    // instruction stream
    input  wire        OP_VALID,
    input  wire [7:0]  OP_BYTE,
    input  wire [7:0]  MODRM_BYTE,
    input  wire [15:0] IMM_DATA,
    input  wire [7:0]  SHIFT_COUNT_LOW_BYTE,
    input  wire [3:0]  EFFECTIVE_ADDRESS_TIME,
    input  wire [15:0] EA_IN,
    input  wire        BUSY_PIN,
    // interrupt pins, asynchronous
    input  wire        NMI_PIN,
    input  wire        INTR_PIN,
    // condition query
    input  wire [3:0]  COND_SEL,
    input  wire [15:0] ALU_FLAGS,
    // register port
    input  wire [3:0]  REG_ADDR,
    input  wire [15:0] REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    output reg  [15:0] REG_RDATA,
    // decode results
    output wire        OP_READY,
    output reg         DIR_TO_REG,
    output reg         WORD_OP,
    output reg  [15:0] IMM_OPERAND,
    output reg  [7:0]  SHIFT_COUNT,
    output wire        REPEAT_GO,
    output wire        COND_TRUE,
    output reg  [9:0]  VECTOR_ADDR,
    // bus side
    output reg         BUS_LOCK,
    output reg         ESC_READ,
    output reg  [15:0] ESC_ADDR,
    output wire        FETCH_EN,
    output wire [19:0] FETCH_ADDR,
    output reg         HALTED
);
    // decodes the processor-control opcodes and the
    // common option bits, holds the registers that
    // reset forces, and drives lock, escape and fetch
    // signals toward the system bus.
    // one clock, synchronous reset
    // architectural registers
    reg [15:0] flags_q;          // flag word
    reg [15:0] code_seg_q;       // code segment
    reg [15:0] ip_q;             // instruction pointer
    reg [15:0] data_segment_q;   // data segment
    reg [15:0] stack_seg_q;      // stack segment
    reg [15:0] extra_segment_q;  // extra segment
    // sequencing state
    reg [3:0]  busy_cnt_q;       // clocks left for current op
    reg        lock_pend_q;      // prefix seen, next op locked
    reg        lock_inst_q;      // locked op in progress
    reg        wait_q;           // waiting on busy pin
    reg        z_bit_q;          // repeat z bit of last opcode
    // synchronisers
    reg [1:0]  nmi_s;            // nmi pin chain
    reg [1:0]  intr_s;           // intr pin chain
    reg [1:0]  busy_s;           // busy pin chain
    reg        nmi_prev_q;       // edge detect on synced nmi

    // escapes share the top five bits 11011
    // is byte an escape opcode
    function is_esc;
        input [7:0] op;
        begin
            is_esc = (op[7:3] == `ESC_TOP);
        end
    endfunction

    // is byte one of the counted control opcodes
    // these carry their own clock count, so a locked
    // one keeps the bus until its count runs out
    function is_ctl;
        input [7:0] op;
        begin
            is_ctl = (op == `OP_DIR_SET) || (op == `OP_INT_CLR) ||
                     (op == `OP_INT_SET) || (op == `OP_HALT) ||
                     (op == `OP_WAIT) || (op == `OP_LOCK);
        end
    endfunction

    // ready drops while an op counts down, while halted
    // and while wait holds for the busy pin.
    // fetch address is the code segment shifted by four
    // plus the pointer; the sum wraps at 20 bits
    // take an opcode only when idle and not halted
    assign OP_READY   = (busy_cnt_q == 4'h0) && !HALTED && !wait_q;
    assign FETCH_EN   = !HALTED;
    assign FETCH_ADDR = {code_seg_q, 4'h0} + {4'h0, ip_q};

    // an opcode is taken at the edge where both are high
    wire take    = OP_VALID && OP_READY;
    wire nmi_rise = nmi_s[1] && !nmi_prev_q;
    // halt ends on an nmi edge or an enabled intr level
    wire wake    = nmi_rise || (intr_s[1] && flags_q[`FLAG_INT]);

    // pins come from outside the clock domain; only the
    // second flop is read, the first may go metastable.
    // nmi acts on a rising edge of the synced level, so
    // the previous sample is kept beside it
    // two-flop synchronisers for pins
    always @(posedge CLK_SYS) begin
        if (RST) begin
            // pins read as idle while reset holds
            nmi_s      <= 2'h0;
            intr_s     <= 2'h0;
            busy_s     <= 2'h0;
            nmi_prev_q <= 1'b0;
        end else begin
            // shift each pin one flop further in
            nmi_s      <= {nmi_s[0], NMI_PIN};
            intr_s     <= {intr_s[0], INTR_PIN};
            busy_s     <= {busy_s[0], BUSY_PIN};
            nmi_prev_q <= nmi_s[1];
        end
    end

    // unsigned tests use carry and zero only; signed
    // tests compare sign with overflow, so a result
    // that wrapped still orders correctly.
    // unused selects answer false
    // condition evaluation from alu flags
    reg cond_v;
    always @* begin
        case (COND_SEL)
            4'h0: cond_v = !ALU_FLAGS[`FLAG_CARRY] && !ALU_FLAGS[`FLAG_ZERO];
            4'h1: cond_v = !ALU_FLAGS[`FLAG_CARRY];
            4'h2: cond_v = ALU_FLAGS[`FLAG_CARRY];
            4'h3: cond_v = ALU_FLAGS[`FLAG_CARRY] || ALU_FLAGS[`FLAG_ZERO];
            4'h4: cond_v = !ALU_FLAGS[`FLAG_ZERO] &&
                           (ALU_FLAGS[`FLAG_SIGN] == ALU_FLAGS[`FLAG_OVF]);
            4'h5: cond_v = ALU_FLAGS[`FLAG_SIGN] == ALU_FLAGS[`FLAG_OVF];
            4'h6: cond_v = ALU_FLAGS[`FLAG_SIGN] != ALU_FLAGS[`FLAG_OVF];
            4'h7: cond_v = ALU_FLAGS[`FLAG_ZERO] ||
                           (ALU_FLAGS[`FLAG_SIGN] != ALU_FLAGS[`FLAG_OVF]);
            // selects 8..15 are not conditions
            default: cond_v = 1'b0;
        endcase
    end
    assign COND_TRUE = cond_v;
    // z of the latched opcode against the live zero flag
    // repeat continues while z bit matches zero flag
    assign REPEAT_GO = (z_bit_q == ALU_FLAGS[`FLAG_ZERO]);

    // the option bits sit in the low two opcode bits:
    // bit 1 reads as d, s or v and bit 0 as w or z,
    // by opcode family; all readings are latched
    // together and the consumer picks the one it needs.
    // the immediate low byte arrives first
    // operand option decode, registered on take
    always @(posedge CLK_SYS) begin
        if (RST) begin
            DIR_TO_REG  <= 1'b0;
            WORD_OP     <= 1'b0;
            IMM_OPERAND <= 16'h0000;
            SHIFT_COUNT <= 8'h00;
            z_bit_q     <= 1'b0;
        end else if (take) begin
            // option fields are captured only on accept
            DIR_TO_REG <= OP_BYTE[1];
            WORD_OP    <= OP_BYTE[0];
            z_bit_q    <= OP_BYTE[0];
            // s:w 01 word, 11 sign-extended byte, else byte
            // immediate width from s:w
            if (OP_BYTE[1:0] == 2'b11)
                IMM_OPERAND <= {{8{IMM_DATA[7]}}, IMM_DATA[7:0]};
            else if (OP_BYTE[1:0] == 2'b01)
                IMM_OPERAND <= IMM_DATA;
            else
                IMM_OPERAND <= {8'h00, IMM_DATA[7:0]};
            // shift count source from v
            SHIFT_COUNT <= OP_BYTE[1] ? SHIFT_COUNT_LOW_BYTE : 8'h01;
        end
    end

    // vector slot for types 0..4 from condition select
    // each slot is four bytes, offset then segment;
    // higher types have no reserved slot here and read
    // as zero, so a stray select is harmless
    always @(posedge CLK_SYS) begin
        if (RST)
            VECTOR_ADDR <= 10'h000;
        else if (COND_SEL <= 4'h4)
            VECTOR_ADDR <= {4'h0, COND_SEL, 2'b00};
        else
            VECTOR_ADDR <= 10'h000;
    end

    // one process owns every architectural register so
    // a software write and an opcode in one cycle are
    // resolved in one place: the opcode, written later,
    // wins for the bits that it changes.
    // busy_cnt_q holds the clocks left after the accept
    // clock, so an N clock op drops ready for N-1
    // cycles after it is taken
    // control opcode execution and register state
    always @(posedge CLK_SYS) begin
        if (RST) begin
            // flags, segments and pointer, plus sequencing state and bus outputs
            flags_q         <= `RST_FLAGS;
            data_segment_q  <= `RST_SEG;
            stack_seg_q     <= `RST_SEG;
            extra_segment_q <= `RST_SEG;
            code_seg_q      <= `RST_CODE_SEG;
            ip_q            <= `RST_IP;
            busy_cnt_q      <= 4'h0;
            lock_pend_q     <= 1'b0;
            lock_inst_q     <= 1'b0;
            wait_q          <= 1'b0;
            HALTED          <= 1'b0;
            BUS_LOCK        <= 1'b0;
            ESC_READ        <= 1'b0;
            ESC_ADDR        <= 16'h0000;
        end else begin
            // escape read is a one-cycle pulse by default
            ESC_READ <= 1'b0;

            // countdown of instruction clocks
            if (busy_cnt_q != 4'h0)
                busy_cnt_q <= busy_cnt_q - 4'h1;

            // locked op ends when its clocks run out
            // the lock must drop on the last counted clock
            if (lock_inst_q && busy_cnt_q == 4'h1) begin
                lock_inst_q <= 1'b0;
                BUS_LOCK    <= 1'b0;
            end

            // wait holds until busy pin drops
            // the busy pin is read only after its two flops
            if (wait_q && !busy_s[1] && busy_cnt_q <= 4'h1)
                wait_q <= 1'b0;

            // halt wakes on interrupt
            if (HALTED && wake)
                HALTED <= 1'b0;

            // software register writes
            // unmapped offsets drop writes; status is read-only
            if (REG_WR) begin
                case (REG_ADDR)
                    `REG_FLAGS:     flags_q         <= REG_WDATA;
                    `REG_CODE_SEG:  code_seg_q      <= REG_WDATA;
                    `REG_IP:        ip_q            <= REG_WDATA;
                    `REG_DATA_SEG:  data_segment_q  <= REG_WDATA;
                    `REG_STACK_SEG: stack_seg_q     <= REG_WDATA;
                    `REG_EXTRA_SEG: extra_segment_q <= REG_WDATA;
                    default: ;
                endcase
            end

            // accept: advance the pointer and decode the
            // opcode; escapes are told by their top five
            // bits, the rest by a full match
            if (take) begin
                ip_q <= ip_q + 16'h0001;
                // a prefix carries lock into next op
                if (lock_pend_q && OP_BYTE != `OP_LOCK) begin
                    lock_pend_q <= 1'b0;
                    lock_inst_q <= 1'b1;
                end
                if (is_esc(OP_BYTE)) begin
                    // seven clocks plus address time, less the accept clock
                    busy_cnt_q <= `CYC_ESC_BASE + EFFECTIVE_ADDRESS_TIME - 4'h1;
                    // mod 11 names a register, so no bus read
                    if (MODRM_BYTE[7:6] != 2'b11) begin
                        ESC_READ <= 1'b1;
                        ESC_ADDR <= EA_IN;
                    end
                end else begin
                    case (OP_BYTE)
                        // string direction to decrement
                        `OP_DIR_SET: begin
                            flags_q[`FLAG_DIR] <= 1'b1;
                            busy_cnt_q <= `CYC_SHORT - 4'h1;
                        end
                        // mask the interrupt request pin
                        `OP_INT_CLR: begin
                            flags_q[`FLAG_INT] <= 1'b0;
                            busy_cnt_q <= `CYC_SHORT - 4'h1;
                        end
                        // unmask the interrupt request pin
                        `OP_INT_SET: begin
                            flags_q[`FLAG_INT] <= 1'b1;
                            busy_cnt_q <= `CYC_SHORT - 4'h1;
                        end
                        // stop fetching until woken
                        `OP_HALT: begin
                            HALTED     <= 1'b1;
                            busy_cnt_q <= `CYC_SHORT - 4'h1;
                        end
                        // hold until the busy pin drops
                        `OP_WAIT: begin
                            wait_q     <= 1'b1;
                            busy_cnt_q <= `CYC_WAIT - 4'h1;
                        end
                        // lock the bus through the next op
                        `OP_LOCK: begin
                            lock_pend_q <= 1'b1;
                            BUS_LOCK    <= 1'b1;
                            busy_cnt_q  <= `CYC_SHORT - 4'h1;
                        end
                        // other opcodes belong to other units
                        default: busy_cnt_q <= 4'h0;
                    endcase
                end
                // other ops hold the lock for their single clock
                if (lock_pend_q && !is_ctl(OP_BYTE) && !is_esc(OP_BYTE)) begin
                    lock_inst_q <= 1'b0;
                    BUS_LOCK    <= 1'b0;
                end
            end
        end
    end
    // the general, pointer and index registers are kept
    // by the datapath; they are not in this block and
    // reset has no path to them
    // general registers live outside; reset never touches them

    // read data stand only in the cycle after the
    // strobe and return to zero otherwise, so a stale
    // value is never taken for a fresh read.
    // status packs wait, pending lock, lock and halt;
    // count shows the clocks left of the current op
    // register read port, data one cycle after strobe
    always @(posedge CLK_SYS) begin
        if (RST)
            REG_RDATA <= 16'h0000;
        else if (REG_RD) begin
            case (REG_ADDR)
                `REG_FLAGS:     REG_RDATA <= flags_q;
                `REG_CODE_SEG:  REG_RDATA <= code_seg_q;
                `REG_IP:        REG_RDATA <= ip_q;
                `REG_DATA_SEG:  REG_RDATA <= data_segment_q;
                `REG_STACK_SEG: REG_RDATA <= stack_seg_q;
                `REG_EXTRA_SEG: REG_RDATA <= extra_segment_q;
                `REG_STATUS:    REG_RDATA <= {12'h000, wait_q, lock_pend_q,
                                              BUS_LOCK, HALTED};
                `REG_COUNT:     REG_RDATA <= {12'h000, busy_cnt_q};
                default:        REG_RDATA <= 16'h0000;
            endcase
        end else
            REG_RDATA <= 16'h0000;
    end
endmodule

// *** testbench/cpu_ctl_asserts.sv ***
`include "cpu_ctl_consts.vh"
module cpu_ctl_asserts (
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST,
    // instruction stream
    input wire logic        OP_VALID,
    input wire logic [7:0]  OP_BYTE,
    input wire logic [7:0]  MODRM_BYTE,
    input wire logic [15:0] IMM_DATA,
    input wire logic [7:0]  SHIFT_COUNT_LOW_BYTE,
    input wire logic [15:0] EA_IN,
    input wire logic [3:0]  COND_SEL,
    input wire logic [15:0] ALU_FLAGS,
    // decode results and bus side
    input wire logic        OP_READY,
    input wire logic        DIR_TO_REG,
    input wire logic        WORD_OP,
    input wire logic [15:0] IMM_OPERAND,
    input wire logic [7:0]  SHIFT_COUNT,
    input wire logic        COND_TRUE,
    input wire logic [9:0]  VECTOR_ADDR,
    input wire logic        ESC_READ,
    input wire logic [15:0] ESC_ADDR,
    input wire logic        FETCH_EN,
    input wire logic [19:0] FETCH_ADDR,
    input wire logic        HALTED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // opcode accepted at this edge
    wire take = OP_VALID && OP_READY;
    // short control opcodes accepted
    sequence short_take;
        take && (OP_BYTE inside {`OP_DIR_SET, `OP_INT_CLR, `OP_INT_SET, `OP_LOCK});
    endsequence
    // busy for one cycle, then ready again
    sequence two_clocks;
        !OP_READY ##1 OP_READY;
    endsequence
    a_dir_bit: assert property (take |=> DIR_TO_REG == $past(OP_BYTE[1]))
        else $error("direction bit decode wrong");
    a_word_bit: assert property (take |=> WORD_OP == $past(OP_BYTE[0]))
        else $error("size bit decode wrong");
    a_imm_full: assert property (take && OP_BYTE[1:0] == 2'b01
        |=> IMM_OPERAND == $past(IMM_DATA)) else $error("full immediate wrong");
    a_imm_sign_ext: assert property (take && OP_BYTE[1:0] == 2'b11
        |=> IMM_OPERAND == {{8{$past(IMM_DATA[7])}}, $past(IMM_DATA[7:0])})
        else $error("extended immediate wrong");
    a_shift_source: assert property (take |=> SHIFT_COUNT ==
        ($past(OP_BYTE[1]) ? $past(SHIFT_COUNT_LOW_BYTE) : 8'h01))
        else $error("shift count wrong");
    a_below_cond: assert property (COND_SEL == 4'h2
        |-> COND_TRUE == ALU_FLAGS[`FLAG_CARRY]) else $error("below wrong");
    a_less_cond: assert property (COND_SEL == 4'h6
        |-> COND_TRUE == (ALU_FLAGS[`FLAG_SIGN] != ALU_FLAGS[`FLAG_OVF]))
        else $error("less wrong");
    a_reset_fetch: assert property ($fell(RST)
        |-> FETCH_ADDR == 20'hFFFF0 && FETCH_EN) else $error("reset fetch wrong");
    a_vector_slot: assert property (COND_SEL <= 4'h4
        |=> VECTOR_ADDR == {4'h0, $past(COND_SEL), 2'b00}) else $error("vector wrong");
    a_short_time: assert property (short_take |=> two_clocks)
        else $error("short op length wrong");
    a_halt_stops: assert property (take && OP_BYTE == `OP_HALT
        |-> ##[1:2] (HALTED && !FETCH_EN)) else $error("halt did not stop fetch");
    a_esc_read: assert property (take && OP_BYTE[7:3] == `ESC_TOP
        && MODRM_BYTE[7:6] != 2'b11 |=> ESC_READ && ESC_ADDR == $past(EA_IN) ##1 !ESC_READ)
        else $error("escape read wrong");
endmodule
bind cpu_control_decode cpu_ctl_asserts u_chk (.*);

// *** testbench/copro_model.sv ***
module copro_model #(
    parameter int BUSY_LEN = 20
) (
    // clock
    input wire logic clk,
    // escape read seen on the bus
    input wire logic start,
    // busy back to the processor
    output logic     busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;  // cycles of work left
    initial cnt_q = 8'h00;
    // starts on the escape read, then stays busy for BUSY_LEN cycles
    always @(posedge clk) begin
        if (start)
            cnt_q <= 8'(BUSY_LEN);
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign busy = (cnt_q != 8'h00);
endmodule

// *** testbench/cpu_control_decode_and_reset_test.sv ***
`include "cpu_ctl_consts.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, a); end end
module cpu_control_decode_and_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs and outputs
    logic        CLK_SYS, RST, OP_VALID, BUSY_PIN, NMI_PIN, INTR_PIN, REG_WR, REG_RD;
    logic [7:0]  OP_BYTE, MODRM_BYTE, SHIFT_COUNT_LOW_BYTE, SHIFT_COUNT;
    logic [15:0] IMM_DATA, EA_IN, ALU_FLAGS, REG_WDATA, REG_RDATA, IMM_OPERAND, ESC_ADDR;
    logic [3:0]  EFFECTIVE_ADDRESS_TIME, COND_SEL, REG_ADDR;
    logic [9:0]  VECTOR_ADDR;
    logic [19:0] FETCH_ADDR;
    logic        OP_READY, DIR_TO_REG, WORD_OP, REPEAT_GO, COND_TRUE, BUS_LOCK;
    logic        ESC_READ, FETCH_EN, HALTED, esc_seen, lock_seen;
    int          errors, compares;
    cpu_control_decode u_cpu_control_decode (.*);
    copro_model u_copro_model (.clk(CLK_SYS), .start(ESC_READ), .busy(BUSY_PIN));
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    // verdict and end of run
    task give_verdict;
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset held for 20 cycles
    task do_reset;
        RST <= 1'b1;
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // one write strobe, then a quiet cycle
    task wr(input [3:0] a, input [15:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // read strobe, data checked in the cycle after
    task rd(input [3:0] a, input [15:0] e);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        @(posedge CLK_SYS);
        `CHK("read data", e, REG_RDATA)
    endtask
    // offer an opcode when ready, count edges until ready again
    task run(input [7:0] o, input [7:0] m, output int n);
        do @(posedge CLK_SYS); while (OP_READY !== 1'b1);
        OP_VALID <= 1'b1;
        OP_BYTE <= o;
        MODRM_BYTE <= m;
        @(posedge CLK_SYS);
        OP_VALID <= 1'b0;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
            if (n == 1) begin
                esc_seen = ESC_READ;
                lock_seen = BUS_LOCK;
            end
        end while (OP_READY !== 1'b1 && n < 300);
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        errors++;
        give_verdict;
    end
    initial begin
        int n;
        logic [15:0] rst_val [6];
        {RST, OP_VALID, NMI_PIN, INTR_PIN, REG_WR, REG_RD} = 6'h00;
        {OP_BYTE, MODRM_BYTE, REG_ADDR, REG_WDATA, COND_SEL, ALU_FLAGS} = 56'h0;
        {EFFECTIVE_ADDRESS_TIME, EA_IN} = 20'h0;
        IMM_DATA = 16'h1280;
        SHIFT_COUNT_LOW_BYTE = 8'h07;
        rst_val = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        do_reset;
        `CHK("fetch address", 20'hFFFF0, FETCH_ADDR)
        for (int i = 0; i < 6; i++) rd(i[3:0], rst_val[i]);
        wr(`REG_FLAGS, 16'h08C1);
        wr(`REG_COUNT, 16'h1234);
        wr(`REG_DATA_SEG, 16'h5555);
        run(`OP_DIR_SET, 8'h00, n);
        `CHK("direction time", 2, n)
        `CHK("to register", 1'b0, DIR_TO_REG)
        `CHK("word size", 1'b1, WORD_OP)
        `CHK("full immediate", 16'h1280, IMM_OPERAND)
        `CHK("shift count one", 8'h01, SHIFT_COUNT)
        `CHK("repeat stop", 1'b0, REPEAT_GO)
        rd(`REG_FLAGS, 16'h0CC1);
        run(`OP_INT_SET, 8'h00, n);
        `CHK("enable time", 2, n)
        rd(`REG_FLAGS, 16'h0EC1);
        run(`OP_INT_CLR, 8'h00, n);
        `CHK("disable time", 2, n)
        rd(`REG_FLAGS, 16'h0CC1);
        run(`OP_LOCK, 8'h00, n);
        `CHK("lock time", 2, n)
        run(`OP_INT_SET, 8'h00, n);
        `CHK("lock held", 1'b1, lock_seen)
        repeat (3) @(posedge CLK_SYS);
        `CHK("lock gone", 1'b0, BUS_LOCK)
        EFFECTIVE_ADDRESS_TIME <= 4'h5;
        EA_IN <= 16'hBEEF;
        run(8'hDB, 8'h06, n);
        `CHK("escape time", 12, n)
        `CHK("escape read", 1'b1, esc_seen)
        `CHK("escape address", 16'hBEEF, ESC_ADDR)
        `CHK("to register", 1'b1, DIR_TO_REG)
        `CHK("extended immediate", 16'hFF80, IMM_OPERAND)
        `CHK("shift count low", 8'h07, SHIFT_COUNT)
        run(`OP_WAIT, 8'h00, n);
        `CHK("wait on busy", 1'b1, n > 3)
        run(`OP_WAIT, 8'h00, n);
        `CHK("wait time", 3, n)
        rd(`REG_FLAGS, 16'h0EC1);
        run(`OP_HALT, 8'h00, n);
        `CHK("halted", 1'b1, HALTED)
        `CHK("fetch stopped", 1'b0, FETCH_EN)
        `CHK("byte size", 1'b0, WORD_OP)
        `CHK("repeat go", 1'b1, REPEAT_GO)
        NMI_PIN <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (HALTED !== 1'b0 && n < 10);
        `CHK("halt left", 1'b0, HALTED)
        NMI_PIN <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            COND_SEL <= i[3:0];
            ALU_FLAGS <= (i < 4) ? 16'h0001 : 16'h0080;
            @(posedge CLK_SYS);
            `CHK("condition", i[1], COND_TRUE)
            @(posedge CLK_SYS);
            `CHK("vector", (i < 5) ? 4 * i : 0, VECTOR_ADDR)
        end
        do_reset;
        rd(`REG_COUNT, 16'h0000);
        rd(`REG_DATA_SEG, 16'h0000);
        rd(4'hF, 16'h0000);
        give_verdict;
    end
endmodule
